// *** hw/adcsr_pkg.sv ***
// Operation
// - Data-in high at start edge: select mode, float output, convert.
// - Conversion is timed internally and ignores the select line.
// - Select low at conversion end: power down, drive a low busy bit.
// - Result shifts out MSB first, one bit per falling shift-clock edge.
// - Select mode with busy bit floats output after edge 19 or select high.
// - Data-in low at start edge selects chain mode.
// - Data-in and start line both low drive the output low.
// - Chain mode: shift clock low at start edge means no busy bit.
// - Chain mode: shift clock high at start edge means a busy bit.
// - Chain mode without busy: load result, present its MSB at end.
// - Chain mode with busy: load result, drive output high at end.
// - Each falling edge emits the next bit and, except the first edge of a busy-bit frame, captures data-in.
// - Upstream busy bits are not passed down the chain.
// - Core powers down at conversion end and powers up at next start.
// - Previous result stays readable while powered down.
// - Conversion length does not depend on shift clock or throughput.
package adcsr_pkg;

  localparam int RES_BITS = 18;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CONV_TIME_NS = 600;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV_CNT_W = 16;
  localparam int EDGE_CNT_W = 5;
  localparam logic [4:0] EDGES_PLAIN = 5'h12;
  localparam logic [4:0] EDGES_BUSY = 5'h13;
  localparam logic [4:0] EDGE_SAT = 5'h1F;
  localparam logic [17:0] RESULT_RST = 18'h00000;
  localparam logic [2:0] PIN_RST = 3'h7;
  localparam logic [4:0] LINK_RST = 5'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_ACQ  = 2'h3
  } adcsr_state_t;

  // Accepts a synchronised level only once the last two stages agree.
  function automatic logic [4:0] adcsr_filter(input logic [4:0] f,
                                              input logic [4:0] s2,
                                              input logic [4:0] s3);
    adcsr_filter = (s2 & ~(s2 ^ s3)) | (f & (s2 ^ s3));
  endfunction

endpackage

// *** hw/adcsr_link_if.sv ***
`timescale 1ns/1ps
interface adcsr_link_if;
  logic [17:0] result;
  logic        busy_first;
  logic        epoch;
  logic        bit_out;
  logic        started;
  logic        past18;
  logic        past19;
  logic        seen;

  modport core (output result, busy_first, epoch,
                input  bit_out, started, past18, past19, seen);
  modport link (input  result, busy_first, epoch,
                output bit_out, started, past18, past19, seen);
endinterface

// *** hw/adcsr_shifter.sv ***
`timescale 1ns/1ps
module adcsr_shifter (
  input wire logic   sclk,
  input wire logic   sys_rst,
  input wire logic   din,
  adcsr_link_if.link lk
);

  // ---------------------------------------------------------------
  // Reset and shift state on the falling shift-clock edge
  // ---------------------------------------------------------------
  // The result word and epoch are written once per conversion and are
  // stable long before the host clocks, so they are read directly.
  logic        rst_s1;
  logic        rst_s2;
  logic [17:0] sh;
  logic [4:0]  cnt;
  logic        seen;
  logic        started;
  logic        past18;
  logic        past19;
  logic [17:0] next_sh;
  logic [4:0]  next_cnt;
  logic        next_seen;
  logic        new_frame;

  assign new_frame = (lk.epoch != seen);

  always_comb begin
    next_seen = seen;
    next_sh   = {sh[16:0], din};
    next_cnt  = (cnt == adcsr_pkg::EDGE_SAT) ? cnt : cnt + 5'h01;
    if (rst_s2) begin
      next_seen = lk.epoch;
      next_sh   = adcsr_pkg::RESULT_RST;
      next_cnt  = 5'h00;
    end else if (new_frame) begin
      next_seen = lk.epoch;
      next_cnt  = 5'h01;
      if (lk.busy_first) begin
        next_sh = lk.result;
      end else begin
        next_sh = {lk.result[16:0], din};
      end
    end
  end

  always_ff @(negedge sclk) begin
    rst_s1  <= sys_rst;
    rst_s2  <= rst_s1;
    sh      <= next_sh;
    cnt     <= next_cnt;
    seen    <= next_seen;
    started <= (next_cnt != 5'h00);
    past18  <= (next_cnt >= adcsr_pkg::EDGES_PLAIN);
    past19  <= (next_cnt >= adcsr_pkg::EDGES_BUSY);
  end

  assign lk.bit_out = sh[17];
  assign lk.started = started;
  assign lk.past18  = past18;
  assign lk.past19  = past19;
  assign lk.seen    = seen;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_shift_in;
    @(negedge sclk) disable iff (rst_s2)
      (!new_frame && !rst_s2) |=> (sh == {$past(sh[16:0]), $past(din)});
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift register did not take data-in");

  property p_drop_busy;
    @(negedge sclk) disable iff (rst_s2)
      (new_frame && lk.busy_first) |=> (sh == $past(lk.result));
  endproperty
  a_drop_busy: assert property (p_drop_busy)
    else $error("upstream busy bit entered the shift register");

endmodule // adcsr_shifter

// *** hw/adcsr_top.sv ***
`timescale 1ns/1ps
module adcsr_top #(
  parameter int conv_cycles = adcsr_pkg::CONV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sclk,
  input  wire logic        conversion_start_line,
  input  wire logic        din,
  input  wire logic [17:0] analog_sample,
  output logic             dout,
  output logic             dout_oe,
  output logic             core_powered
);

  localparam logic [15:0] CONV_LAST =
    16'(conv_cycles - 1);

  adcsr_link_if lk ();

  adcsr_shifter u_shifter (
    .sclk    (sclk),
    .sys_rst (sys_rst),
    .din     (din),
    .lk      (lk.link)
  );

  // ---------------------------------------------------------------
  // Pin and link synchronisers
  // ---------------------------------------------------------------
  // Bits of the pin group: 2 start line, 1 data-in, 0 shift clock.
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_f;
  logic [2:0] next_pin_f;
  // Bits of the link group: 4 bit, 3 started, 2 past18, 1 past19, 0 seen.
  logic [4:0] lnk_s1;
  logic [4:0] lnk_s2;
  logic [4:0] lnk_s3;
  logic [4:0] lnk_f;
  logic [4:0] next_lnk_f;
  logic [4:0] pin_wide;

  always_comb begin
    pin_wide   = adcsr_pkg::adcsr_filter({2'h0, pin_f},
                                         {2'h0, pin_s2},
                                         {2'h0, pin_s3});
    next_pin_f = pin_wide[2:0];
    next_lnk_f = adcsr_pkg::adcsr_filter(lnk_f, lnk_s2, lnk_s3);
    if (sys_rst) begin
      next_pin_f = adcsr_pkg::PIN_RST;
      next_lnk_f = adcsr_pkg::LINK_RST;
    end
  end

  always_ff @(posedge clk) begin
    pin_s1 <= {conversion_start_line, din, sclk};
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    pin_f  <= next_pin_f;
    lnk_s1 <= {lk.bit_out, lk.started, lk.past18, lk.past19, lk.seen};
    lnk_s2 <= lnk_s1;
    lnk_s3 <= lnk_s2;
    lnk_f  <= next_lnk_f;
  end

  logic cv_f;
  logic din_f;
  logic sclk_f;
  logic live;

  assign cv_f   = pin_f[2];
  assign din_f  = pin_f[1];
  assign sclk_f = pin_f[0];

  // ---------------------------------------------------------------
  // Conversion sequencer and output pin
  // ---------------------------------------------------------------
  adcsr_pkg::adcsr_state_t state;
  adcsr_pkg::adcsr_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        cv_prev;
  logic        mode_cs;
  logic        next_mode_cs;
  logic        busy_sel;
  logic        next_busy_sel;
  logic [17:0] sample;
  logic [17:0] next_sample;
  logic [17:0] result;
  logic [17:0] next_result;
  logic        epoch;
  logic        next_epoch;
  logic        next_dout;
  logic        next_dout_oe;
  logic        next_core_powered;
  logic        conv_rise;
  logic        conv_end;
  logic        first_bit;

  assign conv_rise = cv_f && !cv_prev;
  assign conv_end  = (state == adcsr_pkg::ST_CONV) && (cnt == 16'h0000);
  // The link counts only once it has seen this conversion's epoch.
  assign live      = lnk_f[3] && (lnk_f[0] == epoch);
  assign first_bit = busy_sel ? !mode_cs : result[17];

  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_mode_cs      = mode_cs;
    next_busy_sel     = busy_sel;
    next_sample       = sample;
    next_result       = result;
    next_epoch        = epoch;
    next_dout         = dout;
    next_dout_oe      = dout_oe;
    next_core_powered = core_powered;
    unique case (state)
      adcsr_pkg::ST_IDLE,
      adcsr_pkg::ST_ACQ: begin
        if (conv_rise) begin
          next_state        = adcsr_pkg::ST_CONV;
          next_cnt          = CONV_LAST;
          next_mode_cs      = din_f;
          next_busy_sel     = sclk_f;
          next_sample       = analog_sample;
          next_core_powered = 1'b1;
          if (din_f) begin
            next_dout_oe = 1'b0;
          end
        end else if (state == adcsr_pkg::ST_ACQ) begin
          if (mode_cs) begin
            if (din_f) begin
              next_dout_oe = 1'b0;
            end else if (live && (busy_sel ? lnk_f[1] : lnk_f[2])) begin
              next_dout_oe = 1'b0;
            end else begin
              next_dout_oe = 1'b1;
              next_dout    = live ? lnk_f[4] : first_bit;
            end
          end else begin
            next_dout_oe = 1'b1;
            next_dout    = live ? lnk_f[4] : first_bit;
          end
        end
      end
      adcsr_pkg::ST_CONV: begin
        // Only the internal count ends a conversion.
        if (conv_end) begin
          next_state        = adcsr_pkg::ST_ACQ;
          next_result       = sample;
          next_epoch        = !epoch;
          next_core_powered = 1'b0;
          if (mode_cs) begin
            next_busy_sel = !din_f;
            next_dout_oe  = !din_f;
            next_dout     = 1'b0;
          end else begin
            next_dout_oe = 1'b1;
            next_dout    = busy_sel ? 1'b1 : sample[17];
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: begin
        next_state = adcsr_pkg::ST_IDLE;
      end
    endcase
    if (!cv_f && !din_f) begin
      next_dout_oe = 1'b1;
      next_dout    = 1'b0;
    end
    if (sys_rst) begin
      next_state        = adcsr_pkg::ST_IDLE;
      next_cnt          = 16'h0000;
      next_mode_cs      = 1'b1;
      next_busy_sel     = 1'b0;
      next_sample       = adcsr_pkg::RESULT_RST;
      next_result       = adcsr_pkg::RESULT_RST;
      next_epoch        = 1'b0;
      next_dout         = 1'b0;
      next_dout_oe      = 1'b0;
      next_core_powered = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state        <= next_state;
    cnt          <= next_cnt;
    cv_prev      <= sys_rst ? 1'b1 : cv_f;
    mode_cs      <= next_mode_cs;
    busy_sel     <= next_busy_sel;
    sample       <= next_sample;
    result       <= next_result;
    epoch        <= next_epoch;
    dout         <= next_dout;
    dout_oe      <= next_dout_oe;
    core_powered <= next_core_powered;
  end

  assign lk.result     = result;
  assign lk.busy_first = busy_sel;
  assign lk.epoch      = epoch;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] conv_len;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_len <= 16'h0000;
    end else if (core_powered) begin
      conv_len <= conv_len + 16'h0001;
    end else begin
      conv_len <= 16'h0000;
    end
  end

  sequence s_cs_start;
    conv_rise && din_f && (state != adcsr_pkg::ST_CONV);
  endsequence

  sequence s_end_busy_cs;
    conv_end && mode_cs && !din_f && cv_f;
  endsequence

  property p_cs_float;
    @(posedge clk) disable iff (sys_rst)
      s_cs_start |=> !dout_oe && core_powered;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("select-mode start did not float the output");

  property p_conv_len;
    @(posedge clk) disable iff (sys_rst)
      $fell(core_powered) |-> (conv_len == 16'(conv_cycles));
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length differs from the set count");

  property p_busy_low;
    @(posedge clk) disable iff (sys_rst)
      s_end_busy_cs |=> dout_oe && !dout ##1 !core_powered;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy bit not driven low at conversion end");

  property p_sel_high_float;
    @(posedge clk) disable iff (sys_rst)
      (state == adcsr_pkg::ST_ACQ && mode_cs && din_f && !conv_rise)
      |=> !dout_oe;
  endproperty
  a_sel_high_float: assert property (p_sel_high_float)
    else $error("output driven while select is high");

  property p_both_low;
    @(posedge clk) disable iff (sys_rst)
      (!cv_f && !din_f) |=> dout_oe && !dout;
  endproperty
  a_both_low: assert property (p_both_low)
    else $error("output not driven low with both lines low");

  property p_chain_msb;
    @(posedge clk) disable iff (sys_rst)
      (conv_end && !mode_cs && !busy_sel && cv_f)
      |=> dout_oe && (dout == result[17]);
  endproperty
  a_chain_msb: assert property (p_chain_msb)
    else $error("chain mode did not present the MSB");

  property p_chain_busy;
    @(posedge clk) disable iff (sys_rst)
      (conv_end && !mode_cs && busy_sel && cv_f) |=> dout_oe && dout;
  endproperty
  a_chain_busy: assert property (p_chain_busy)
    else $error("chain busy bit not driven high");

  property p_power_cycle;
    @(posedge clk) disable iff (sys_rst)
      conv_end |=> !core_powered && (state == adcsr_pkg::ST_ACQ);
  endproperty
  a_power_cycle: assert property (p_power_cycle)
    else $error("core stayed powered after conversion end");

  property p_result_kept;
    @(posedge clk) disable iff (sys_rst)
      (state == adcsr_pkg::ST_ACQ) [*2] |-> $stable(result);
  endproperty
  a_result_kept: assert property (p_result_kept)
    else $error("result changed during acquisition");

  property p_mode_latch;
    @(posedge clk) disable iff (sys_rst)
      (conv_rise && state != adcsr_pkg::ST_CONV)
      |=> (mode_cs == $past(din_f)) && (busy_sel == $past(sclk_f));
  endproperty
  a_mode_latch: assert property (p_mode_latch)
    else $error("mode not taken from the lines at start");

endmodule // adcsr_top

// *** bench/adcsr_host_model.sv ***
`timescale 1ns/1ps
module adcsr_host_model (
  input  wire logic dout,
  input  wire logic dout_oe,
  output logic      sclk,
  output logic      up_bit
);
  logic        idle_lvl;
  logic [18:0] up_w;
  logic [36:0] cap;
  wire logic   line;

  // The pulled-up line reads high whenever the device floats it.
  assign line   = dout_oe ? dout : 1'b1;
  assign up_bit = up_w[18];

  initial begin
    idle_lvl = 1'b0;
    sclk     = 1'b0;
    up_w     = 19'h00000;
    cap      = 37'h0000000000;
  end

  // Idle level of the shift clock picks the busy bit in chain mode.
  task automatic set_idle(input logic v);
    idle_lvl = v;
    sclk     = v;
  endtask

  task automatic load_up(input logic [18:0] w);
    up_w = w;
  endtask

  // Gives n falling edges, sampling the line just before each one.
  task automatic frame(input int n);
    #3;
    sclk = 1'b1;
    #24;
    for (int i = 0; i < n; i++) begin
      cap  = {cap[35:0], line};
      sclk = 1'b0;
      #24;
      if (i < n - 1 || idle_lvl) begin
        up_w = {up_w[17:0], ~up_w[0]};
        sclk = 1'b1;
        #24;
      end
    end
  endtask
endmodule // adcsr_host_model

// *** bench/adcsr_top_test.sv ***
`timescale 1ns/1ps
module adcsr_top_test;
  localparam int conv_n = 10;
  logic        clk;
  logic        sys_rst;
  logic        start;
  logic        din_drv;
  logic        chain_up;
  logic [17:0] sample;
  logic        dout;
  logic        dout_oe;
  logic        core_powered;
  logic        sclk;
  logic        up_bit;
  wire logic   din;
  int          n_fail;
  int          total_checks;
  int          cycles;

  assign din = chain_up ? up_bit : din_drv;

  adcsr_top #(.conv_cycles(conv_n)) dut (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .sclk                 (sclk),
    .conversion_start_line(start),
    .din                  (din),
    .analog_sample        (sample),
    .dout                 (dout),
    .dout_oe              (dout_oe),
    .core_powered         (core_powered)
  );

  adcsr_host_model host (
    .dout   (dout),
    .dout_oe(dout_oe),
    .sclk   (sclk),
    .up_bit (up_bit)
  );

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Select mode raises din before lowering the start line.
  task automatic start_conv(input logic dl, input logic sh,
                            input logic [17:0] v);
    @(negedge clk);
    din_drv = dl;
    sample  = v;
    host.set_idle(sh);
    repeat (2) @(negedge clk);
    start = 1'b0;
    repeat (6) @(negedge clk);
    if (!dl)
      check(37'({dout_oe, dout}), 37'h2);
    start = 1'b1;
  endtask

  // Times the powered phase; din takes its end level mid-conversion.
  task automatic run_conv(input logic din_end);
    int k;
    k = 0;
    while (core_powered !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (din_drv)
      check(37'(dout_oe), 37'h0);
    k = 0;
    while (core_powered === 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
      if (k == 2)
        din_drv = din_end;
    end
    check(37'(k), 37'(conv_n));
    repeat (8) @(negedge clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic chain_plain;
    start_conv(1'b0, 1'b0, 18'h2D5A3);
    run_conv(1'b0);
    check(37'({dout_oe, dout}), 37'h3);
    host.load_up({18'h1C3E5, 1'b0});
    chain_up = 1'b1;
    host.frame(36);
    chain_up = 1'b0;
    check(37'(host.cap[35:0]), {1'h0, 18'h2D5A3, 18'h1C3E5});
  endtask

  task automatic select_busy;
    start_conv(1'b1, 1'b0, 18'h3A5C1);
    run_conv(1'b0);
    check(37'({dout_oe, dout}), 37'h2);
    host.frame(19);
    check(37'(host.cap[18:0]), 37'({1'h0, 18'h3A5C1}));
    repeat (8) @(negedge clk);
    check(37'(dout_oe), 37'h0);
  endtask

  task automatic select_abort;
    start_conv(1'b1, 1'b0, 18'h20001);
    run_conv(1'b0);
    host.frame(5);
    check(37'(host.cap[4:0]), 37'h08);
    @(negedge clk);
    din_drv = 1'b1;
    repeat (8) @(negedge clk);
    check(37'(dout_oe), 37'h0);
  endtask

  task automatic select_plain;
    start_conv(1'b1, 1'b0, 18'h15A5A);
    run_conv(1'b1);
    check(37'(dout_oe), 37'h0);
    din_drv = 1'b0;
    repeat (8) @(negedge clk);
    check(37'({dout_oe, dout}), 37'h2);
    host.frame(18);
    check(37'(host.cap[17:0]), 37'(18'h15A5A));
    repeat (8) @(negedge clk);
    check(37'(dout_oe), 37'h0);
  endtask

  task automatic chain_busy;
    start_conv(1'b0, 1'b1, 18'h0F0F3);
    run_conv(1'b0);
    check(37'({dout_oe, dout}), 37'h3);
    host.load_up({1'h1, 18'h2AAB5});
    chain_up = 1'b1;
    host.frame(37);
    chain_up = 1'b0;
    check(host.cap, {1'h1, 18'h0F0F3, 18'h2AAB5});
  endtask

  initial begin
    clk          = 1'b0;
    sys_rst      = 1'b1;
    start        = 1'b1;
    din_drv      = 1'b1;
    chain_up     = 1'b0;
    sample       = 18'h00000;
    n_fail       = 0;
    total_checks = 0;
    cycles       = 0;
    fork
      host.frame(3);
    join_none
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    // Two shift-clock edges flush the reset out of the link domain.
    host.frame(2);
    repeat (2) @(negedge clk);
    chain_plain();
    select_busy();
    select_abort();
    select_plain();
    chain_busy();
    complete_run();
  end
endmodule // adcsr_top_test
